// [cbp_ctrl.sv]
// What this block does
// - balancing started in active mode keeps running after sleep is requested
// - when enabled cell and module balancing have completed, enter the power mode chosen by completion action
// - pause on hot die, hot thermistor when enabled, or host pause request
// - host pause request accepted at any time after start
// - pause turns all switches off, freezes channel timers, sets pause-active flag
// - faults during pause never end cell balancing
// - leaving pause resumes countdown and channels with non-zero timers that were not stopped at the cell stop voltage
// - start with all timers zero: no balancing, completion flag stays 0
// - non-zero timer but all cells below stop voltage: start, stop, set complete
// - one countdown timer per channel, frozen while paused
// - readback load copies selected channel's remaining time to readback register
// - readback shows 0xFF while balancing is idle (never started, or started with all channel timers zero)
// - module balancing drives GPIO3 load output and sets module-running flag
// - with aux converter running and sleep not requested, stack below stop voltage ends module balancing
// - zeroed module timer plus start, or fault abort, ends it without complete
// - module balancing is never paused
// - without aux converter, stack voltage is ignored: module balancing ends by timer, zeroed-timer start or fault abort
// - completion action waits for module and cell completion, each only if enabled
// - fault abort of cell balancing sets the fault-abort flag
// - die pause above warning, resume below warning minus hysteresis
`timescale 1ns/1ps
module cbp_ctrl
   import cbp_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
) (
   input  wire logic           clk_i,             // system clock, 20 MHz
   input  wire logic           rst_i,             // sync reset, active high
   input  wire logic           wb_cyc_i,          // wishbone cycle
   input  wire logic           wb_stb_i,          // wishbone strobe
   input  wire logic           wb_we_i,           // wishbone write
   input  wire logic [AW-1:0]  wb_adr_i,          // byte address
   input  wire logic [3:0]     wb_sel_i,          // byte lanes
   input  wire logic [31:0]    wb_dat_i,          // write data
   output logic      [31:0]    wb_dat_o,          // read data
   output logic                wb_ack_o,          // acknowledge
   input  wire logic [7:0]     die_temp_i,        // hottest die sensor, degrees
   input  wire logic           therm_over_i,      // thermistor above pause threshold
   input  wire logic [NCH-1:0] cell_below_stop_i, // cell under stop voltage
   input  wire logic           fault_i,           // unmasked fault present
   input  wire logic           aux_running_i,     // aux converter running
   input  wire logic [VW-1:0]  stack_voltage_i,   // aux stack result
   output logic [NCH-1:0]      balance_switch_o,  // switch gates
   output logic                gpio3_o,           // module load drive
   output logic                gpio3_oe_o,        // module load enable
   output logic [1:0]          power_mode_o       // requested power mode
);
   localparam int TKW = $clog2(TICKS);

   initial begin
      if (TICKS < 2) $error("TICKS must be at least 2");
      if (NCH > 16) $error("channel select holds at most 16 channels");
   end

   typedef struct packed {
      cbp_state_t                st;
      logic                      start;
      logic                      rbld;
      logic                      pause;
      logic                      tpen;
      logic                      faen;
      logic [1:0]                act;
      logic                      sleep;
      logic [3:0]                sel;
      logic [VW-1:0]             cstop;
      logic [VW-1:0]             mstop;
      logic [TW-1:0]             msetting;
      logic [NCH-1:0][TW-1:0]    csetting;
      logic                      cell_bal_complete_flag;
      logic                      cb_en;
      logic                      module_running_flag;
      logic                      module_complete_flag;
      logic                      mb_en;
      logic                      fa_flag;
      logic                      pm_entered;
      logic                      die_hot;
      logic [NCH-1:0]            chan_stop;
      logic [TW-1:0]             remain;
      logic [NCH-1:0]            sw;
      logic                      gpio;
      logic [1:0]                pmode;
      logic                      ack;
      logic [31:0]               rdat;
      logic [TKW-1:0]            tick;
   } cbp_regs_t;

   cbp_regs_t r_ff;
   cbp_regs_t nxt_r;

   logic [NCH-1:0][TW-1:0] cnt;
   logic [TW-1:0]          mcnt;
   logic                   tick_now;

   function automatic logic [31:0] wmerge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (d & m);
   endfunction : wmerge

   assign tick_now = (r_ff.tick == TKW'(TICKS - 1));

   // timers only move in RUN: paused channels keep their count
   for (genvar i = 0; i < NCH; i++) begin : g_cell_tmr
      cbp_timer #(.W(TW)) u_tmr (
         .clk_i  (clk_i),
         .rst_i  (rst_i),
         .load_i (r_ff.start),
         .val_i  (r_ff.csetting[i]),
         .run_i  (tick_now && r_ff.st == CBP_RUN && !r_ff.chan_stop[i]),
         .cnt_o  (cnt[i])
      );
   end

   // module timer counts the programmed setting down; zero means setting reached
   cbp_timer #(.W(TW)) u_mod_tmr (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (r_ff.start),
      .val_i  (r_ff.msetting),
      .run_i  (tick_now && r_ff.module_running_flag),
      .cnt_o  (mcnt)
   );

   logic [31:0] ctrl_img;
   logic [31:0] stat_img;
   logic [31:0] wv;
   logic        req;
   logic        pause_req;
   logic        all_fin;
   logic [3:0]  cidx;

   always_comb begin
      ctrl_img = '0;
      ctrl_img[CTRL_PAUSE] = r_ff.pause;
      ctrl_img[CTRL_TPEN] = r_ff.tpen;
      ctrl_img[CTRL_FAEN] = r_ff.faen;
      ctrl_img[CTRL_ACT +: 2] = r_ff.act;
      ctrl_img[CTRL_SLEEP] = r_ff.sleep;
      ctrl_img[CTRL_SEL +: 4] = r_ff.sel;
      stat_img = '0;
      stat_img[ST_CBDONE] = r_ff.cell_bal_complete_flag;
      stat_img[ST_INPAUSE] = (r_ff.st == CBP_PAUSE);
      stat_img[ST_MBRUN] = r_ff.module_running_flag;
      stat_img[ST_MBDONE] = r_ff.module_complete_flag;
      stat_img[ST_FABORT] = r_ff.fa_flag;
      stat_img[ST_CBRUN] = (r_ff.st == CBP_RUN);
      stat_img[ST_PMODE +: 2] = r_ff.pmode;
      all_fin = 1'b1;
      for (int i = 0; i < NCH; i++) begin
         if (cnt[i] != '0 && !r_ff.chan_stop[i]) all_fin = 1'b0;
      end
      cidx = wb_adr_i[5:2];
      wv = '0;
      pause_req = 1'b0;

      nxt_r = r_ff;
      nxt_r.start = 1'b0;
      nxt_r.rbld = 1'b0;
      nxt_r.ack = 1'b0;
      nxt_r.tick = tick_now ? '0 : r_ff.tick + TKW'(1);

      // wishbone: one wait cycle, ack for exactly one cycle
      req = wb_cyc_i && wb_stb_i && !r_ff.ack;
      if (req) begin
         nxt_r.ack = 1'b1;
         unique case (wb_adr_i[AW-1:2])
            A_CTRL[AW-1:2]:   nxt_r.rdat = ctrl_img;
            A_STAT[AW-1:2]:   nxt_r.rdat = stat_img;
            A_REMAIN[AW-1:2]: nxt_r.rdat = 32'(r_ff.remain);
            A_CSTOP[AW-1:2]:  nxt_r.rdat = 32'(r_ff.cstop);
            A_MSTOP[AW-1:2]:  nxt_r.rdat = 32'(r_ff.mstop);
            A_MTIMER[AW-1:2]: nxt_r.rdat = 32'(r_ff.msetting);
            default: begin
               if (wb_adr_i[7:6] == A_CTIM_HI && 32'(cidx) < NCH) begin
                  nxt_r.rdat = 32'(r_ff.csetting[cidx]);
               end else begin
                  nxt_r.rdat = '0;
               end
            end
         endcase
         if (wb_we_i) begin
            unique case (wb_adr_i[AW-1:2])
               A_CTRL[AW-1:2]: begin
                  wv = wmerge(ctrl_img, wb_dat_i, wb_sel_i);
                  nxt_r.start = wv[CTRL_START] & wb_sel_i[0];
                  nxt_r.rbld = wv[CTRL_RBLD] & wb_sel_i[0];
                  nxt_r.pause = wv[CTRL_PAUSE];
                  nxt_r.tpen = wv[CTRL_TPEN];
                  nxt_r.faen = wv[CTRL_FAEN];
                  nxt_r.act = wv[CTRL_ACT +: 2];
                  nxt_r.sleep = wv[CTRL_SLEEP];
                  nxt_r.sel = wv[CTRL_SEL +: 4];
               end
               A_CSTOP[AW-1:2]: begin
                  wv = wmerge(32'(r_ff.cstop), wb_dat_i, wb_sel_i);
                  nxt_r.cstop = wv[VW-1:0];
               end
               A_MSTOP[AW-1:2]: begin
                  wv = wmerge(32'(r_ff.mstop), wb_dat_i, wb_sel_i);
                  nxt_r.mstop = wv[VW-1:0];
               end
               A_MTIMER[AW-1:2]: begin
                  wv = wmerge(32'(r_ff.msetting), wb_dat_i, wb_sel_i);
                  nxt_r.msetting = wv[TW-1:0];
               end
               default: begin
                  if (wb_adr_i[7:6] == A_CTIM_HI && 32'(cidx) < NCH) begin
                     wv = wmerge(32'(r_ff.csetting[cidx]), wb_dat_i, wb_sel_i);
                     nxt_r.csetting[cidx] = wv[TW-1:0];
                  end
               end
            endcase
         end
      end

      // die sensor pause with hysteresis
      if (die_temp_i > DIE_WARN_C) begin
         nxt_r.die_hot = 1'b1;
      end else if (die_temp_i < DIE_WARN_C - DIE_HYS_C) begin
         nxt_r.die_hot = 1'b0;
      end
      pause_req = r_ff.pause || (r_ff.tpen && therm_over_i) || r_ff.die_hot;

      // sleep is not looked at here: balancing carries on regardless
      unique case (r_ff.st)
         CBP_IDLE, CBP_DONE: begin
         end
         CBP_RUN: begin
            if (r_ff.faen && fault_i) begin
               nxt_r.st = CBP_DONE;
               nxt_r.fa_flag = 1'b1;
            end else if (pause_req) begin
               nxt_r.st = CBP_PAUSE;
            end else if (all_fin) begin
               nxt_r.st = CBP_DONE;
               nxt_r.cell_bal_complete_flag = 1'b1;
            end else begin
               nxt_r.chan_stop = r_ff.chan_stop | cell_below_stop_i;
            end
         end
         CBP_PAUSE: begin
            // faults are ignored here on purpose, diagnostics inject them
            if (!pause_req) nxt_r.st = CBP_RUN;
         end
      endcase

      if (r_ff.module_running_flag) begin
         if (r_ff.faen && fault_i) begin
            nxt_r.module_running_flag = 1'b0;
         end else if (mcnt == '0) begin
            nxt_r.module_running_flag = 1'b0;
            nxt_r.module_complete_flag = 1'b1;
         end else if (aux_running_i && !r_ff.sleep && stack_voltage_i < r_ff.mstop) begin
            nxt_r.module_running_flag = 1'b0;
            nxt_r.module_complete_flag = 1'b1;
         end
      end

      // a fresh start overrides all completion state
      if (r_ff.start) begin
         nxt_r.chan_stop = '0;
         nxt_r.fa_flag = 1'b0;
         nxt_r.cell_bal_complete_flag = 1'b0;
         nxt_r.pm_entered = 1'b0;
         nxt_r.cb_en = (r_ff.csetting != '0);
         nxt_r.st = (r_ff.csetting != '0) ? CBP_RUN : CBP_IDLE;
         nxt_r.mb_en = (r_ff.msetting != '0);
         nxt_r.module_running_flag = (r_ff.msetting != '0);
         nxt_r.module_complete_flag = 1'b0;
      end

      if (r_ff.rbld) begin
         nxt_r.remain = (r_ff.st == CBP_IDLE) ? REMAIN_STOPPED : cnt[r_ff.sel];
      end

      for (int i = 0; i < NCH; i++) begin
         nxt_r.sw[i] = nxt_r.st == CBP_RUN && !nxt_r.chan_stop[i] && cnt[i] != '0;
      end
      nxt_r.gpio = nxt_r.module_running_flag;

      if (!r_ff.pm_entered && (r_ff.cb_en || r_ff.mb_en) &&
          (!r_ff.cb_en || r_ff.cell_bal_complete_flag) && (!r_ff.mb_en || r_ff.module_complete_flag) && !r_ff.start) begin
         nxt_r.pm_entered = 1'b1;
         nxt_r.pmode = r_ff.act;
      end else if (!r_ff.pm_entered) begin
         nxt_r.pmode = r_ff.sleep ? PM_SLEEP : PM_ACTIVE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_ff <= '0;
         r_ff.remain <= REMAIN_STOPPED;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign wb_dat_o = r_ff.rdat;
   assign wb_ack_o = r_ff.ack;
   assign balance_switch_o = r_ff.sw;
   assign gpio3_o = r_ff.gpio;
   assign gpio3_oe_o = r_ff.gpio;
   assign power_mode_o = r_ff.pmode;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [TW-1:0] sel_cnt;
   assign sel_cnt = cnt[r_ff.sel];

   sequence s_paused2;
      r_ff.st == CBP_PAUSE ##1 r_ff.st == CBP_PAUSE;
   endsequence

   a_pause_sw_off: assert property (
      r_ff.st == CBP_PAUSE |-> balance_switch_o == '0)
      else $error("switches on while paused");

   a_pause_frozen: assert property (
      s_paused2 |-> $stable(cnt))
      else $error("timer moved while paused");

   a_pause_no_abort: assert property (
      r_ff.st == CBP_PAUSE && fault_i |=> r_ff.st != CBP_DONE)
      else $error("pause ended by fault");

   a_zero_start: assert property (
      r_ff.start && r_ff.csetting == '0 |=> r_ff.st == CBP_IDLE && !r_ff.cell_bal_complete_flag [*2])
      else $error("all-zero start began balancing");

   a_readback_copy: assert property (
      r_ff.rbld && r_ff.st != CBP_IDLE |=> r_ff.remain == $past(sel_cnt))
      else $error("readback value wrong");

   a_readback_stopped: assert property (
      r_ff.rbld && r_ff.st == CBP_IDLE |=> r_ff.remain == REMAIN_STOPPED)
      else $error("stopped readback not 0xFF");

   a_mod_timer_end: assert property (
      r_ff.module_running_flag && mcnt == '0 && !r_ff.start && !(r_ff.faen && fault_i)
      |=> !r_ff.module_running_flag && r_ff.module_complete_flag ##1 !gpio3_oe_o)
      else $error("module timer expiry missed");

   a_mod_no_pause: assert property (
      r_ff.module_running_flag && mcnt > TW'(1) && !fault_i && !aux_running_i && !r_ff.start
      |=> r_ff.module_running_flag)
      else $error("module balancing stopped without cause");

   a_single_shot: assert property (
      r_ff.start |=> !r_ff.start || $past(req))
      else $error("start held longer than one cycle");

   a_action_entry: assert property (
      $rose(r_ff.pm_entered) |=> power_mode_o == $past(r_ff.act, 2))
      else $error("completion power mode not applied");
endmodule : cbp_ctrl

// [cbp_pkg.sv]
package cbp_pkg;
   localparam int NCH      = 16;        // balancing channels
   localparam int TW       = 8;         // timer width
   localparam int VW       = 16;        // voltage code width
   localparam int AW       = 8;         // byte address width

   localparam logic [AW-1:0] A_CTRL   = 8'h00;
   localparam logic [AW-1:0] A_STAT   = 8'h04;
   localparam logic [AW-1:0] A_REMAIN = 8'h08;
   localparam logic [AW-1:0] A_CSTOP  = 8'h0C;
   localparam logic [AW-1:0] A_MSTOP  = 8'h10;
   localparam logic [AW-1:0] A_MTIMER = 8'h14;
   localparam logic [1:0]    A_CTIM_HI = 2'h1; // 0x40 + 4*channel

   localparam int CTRL_START = 0;
   localparam int CTRL_PAUSE = 1;
   localparam int CTRL_TPEN  = 2;
   localparam int CTRL_FAEN  = 3;
   localparam int CTRL_ACT   = 4;       // two bits
   localparam int CTRL_RBLD  = 6;
   localparam int CTRL_SLEEP = 7;
   localparam int CTRL_SEL   = 8;       // four bits

   localparam int ST_CBDONE  = 0;
   localparam int ST_INPAUSE = 1;
   localparam int ST_MBRUN   = 2;
   localparam int ST_MBDONE  = 3;
   localparam int ST_FABORT  = 4;
   localparam int ST_CBRUN   = 5;
   localparam int ST_PMODE   = 6;       // two bits

   localparam logic [TW-1:0] REMAIN_STOPPED = 8'hFF;
   localparam logic [1:0]    PM_ACTIVE      = 2'h0;
   localparam logic [1:0]    PM_SLEEP       = 2'h1;
   localparam logic [1:0]    PM_SHUTDOWN    = 2'h2;

   localparam logic [7:0]    DIE_WARN_C = 8'h69;  // 105 degrees
   localparam logic [7:0]    DIE_HYS_C  = 8'h0A;

   localparam int TICK_UNIT_NS  = 1000000000;     // one timer unit, 1 s
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_CYCLES   = TICK_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      CBP_IDLE  = 2'b00,
      CBP_RUN   = 2'b01,
      CBP_PAUSE = 2'b11,
      CBP_DONE  = 2'b10
   } cbp_state_t;
endpackage : cbp_pkg

// [cbp_timer.sv]
`timescale 1ns/1ps
module cbp_timer
   import cbp_pkg::*;
#(
   parameter int W = TW
) (
   input  wire logic         clk_i,  // system clock
   input  wire logic         rst_i,  // sync reset
   input  wire logic         load_i, // load start value
   input  wire logic [W-1:0] val_i,  // start value
   input  wire logic         run_i,  // count one unit down
   output logic      [W-1:0] cnt_o   // remaining units
);
   initial begin
      if (W < 1) $error("timer width must be positive");
   end

   typedef struct packed {
      logic [W-1:0] cnt;
   } cbp_tmr_t;

   cbp_tmr_t r_ff;
   cbp_tmr_t nxt_r;

   always_comb begin
      nxt_r = r_ff;
      if (load_i) begin
         nxt_r.cnt = val_i;
      end else if (run_i && r_ff.cnt != '0) begin
         nxt_r.cnt = r_ff.cnt - W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign cnt_o = r_ff.cnt;
endmodule : cbp_timer

// [cbp_ctrl_test.sv]
`timescale 1ns/1ps
module cbp_ctrl_test;
   import cbp_pkg::*;
   localparam logic [31:0] C_GO   = 32'h1 << CTRL_START;
   localparam logic [31:0] C_PS   = 32'h1 << CTRL_PAUSE;
   localparam logic [31:0] C_TP   = 32'h1 << CTRL_TPEN;
   localparam logic [31:0] C_FA   = 32'h1 << CTRL_FAEN;
   localparam logic [31:0] C_RB   = 32'h1 << CTRL_RBLD;
   localparam logic [31:0] C_SL   = 32'h1 << CTRL_SLEEP;
   localparam logic [31:0] C_SHUT = 32'(PM_SHUTDOWN) << CTRL_ACT;
   localparam logic [31:0] C_SLP  = 32'(PM_SLEEP) << CTRL_ACT;

   logic           clk_i;
   logic           rst_i;
   logic           cyc;
   logic           stb;
   logic           we;
   logic [AW-1:0]  adr;
   logic [3:0]     sel;
   logic [31:0]    dat_w;
   logic [31:0]    dat_r;
   logic           ack;
   logic [7:0]     die_temp;
   logic           therm_over;
   logic           fault;
   logic           aux_running;
   logic [NCH-1:0] below;
   logic [VW-1:0]  stack;
   logic [NCH-1:0] switches;
   logic           gpio3;
   logic           gpio3_oe;
   logic [1:0]     pmode;
   int             fails;
   int             checks;
   logic [31:0]    d;
   logic [31:0]    r1;
   logic [31:0]    r2;

   cbp_ctrl #(.TICKS(4)) cbp_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .die_temp_i(die_temp), .therm_over_i(therm_over), .cell_below_stop_i(below),
      .fault_i(fault), .aux_running_i(aux_running), .stack_voltage_i(stack),
      .balance_switch_o(switches), .gpio3_o(gpio3), .gpio3_oe_o(gpio3_oe),
      .power_mode_o(pmode));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task end_sim;
      if (fails == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t register got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task chk_pin(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t pins got %h expected %h", $time, got, exp);
      end
   endtask : chk_pin

   task settle(input int n);
      repeat (n) @(negedge clk_i);
   endtask : settle

   // classic cycle: hold everything until ack is sampled high
   task wb_cycle(input logic w, input logic [AW-1:0] a, input logic [31:0] wd,
                 output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_w <= wd;
      sel   <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat_r;
      if (n >= 20) begin
         fails++;
         $display("CHECK FAILED %0t bus timeout", $time);
         end_sim();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb_cycle

   task wr(input logic [AW-1:0] a, input logic [31:0] v);
      logic [31:0] x;
      wb_cycle(1'b1, a, v, x);
   endtask : wr

   task rd(input logic [AW-1:0] a, output logic [31:0] v);
      wb_cycle(1'b0, a, 32'h0, v);
   endtask : rd

   task wait_st(input int b, input logic v);
      int n;
      logic [31:0] s;
      n = 0;
      do begin
         rd(A_STAT, s);
         n++;
      end while (s[b] !== v && n < 300);
      chk_reg(32'(s[b]), 32'(v));
   endtask : wait_st

   // base must not carry the start bit, or the readback would restart balancing
   task rb(input logic [31:0] base, input int ch, output logic [31:0] v);
      wr(A_CTRL, base | C_RB | (32'(ch) << CTRL_SEL));
      settle(3);
      rd(A_REMAIN, v);
   endtask : rb

   task ctim(input int ch, input logic [31:0] v);
      wr({A_CTIM_HI, 4'(ch), 2'b00}, v);
   endtask : ctim

   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      end_sim();
   end

   initial begin
      fails = 0; checks = 0; rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
      adr = '0; sel = 4'h0; dat_w = '0; die_temp = 8'h19; therm_over = 1'b0;
      fault = 1'b0; aux_running = 1'b0; below = '0; stack = '0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(A_REMAIN, d); chk_reg(d, 32'(REMAIN_STOPPED));
      rd(A_STAT, d); chk_reg(d, 32'h0);
      rd(8'h30, d); chk_reg(d, 32'h0);
      wr(A_CSTOP, 32'h1234); rd(A_CSTOP, d); chk_reg(d, 32'h1234);
      wr(A_MSTOP, 32'h0F0F); rd(A_MSTOP, d); chk_reg(d, 32'h0F0F);
      // start with every timer zero
      wr(A_CTRL, C_GO); settle(6);
      rd(A_STAT, d); chk_reg(d & 32'h21, 32'h0);
      chk_pin(32'(switches), 32'h0);
      rb(32'h0, 0, d); chk_reg(d, 32'(REMAIN_STOPPED));
      // two channels, shutdown on completion
      ctim(0, 32'h14); ctim(5, 32'h28);
      wr(A_CTRL, C_SHUT | C_FA | C_GO); settle(4);
      chk_pin(32'(switches), 32'h0021);
      rd(A_CTRL, d); chk_reg(d & (C_GO | C_RB), 32'h0);
      wr(A_CTRL, C_SHUT | C_FA | C_SL); settle(4);
      chk_pin(32'(switches), 32'h0021);
      wr(A_CTRL, C_SHUT | C_FA | C_PS); wait_st(ST_INPAUSE, 1'b1);
      chk_pin(32'(switches), 32'h0);
      @(posedge clk_i) fault <= 1'b1;
      settle(10);
      rd(A_STAT, d); chk_reg(d & 32'h11, 32'h0);
      @(posedge clk_i) fault <= 1'b0;
      rb(C_SHUT | C_FA | C_PS, 5, r1); settle(40); rb(C_SHUT | C_FA | C_PS, 5, r2);
      chk_reg(r2, r1);
      chk_reg(32'(r1 > 0 && r1 < 32'h28), 32'h1);
      wr(A_CTRL, C_SHUT | C_FA); settle(4);
      chk_pin(32'(switches), 32'h0021);
      settle(8); rb(C_SHUT | C_FA, 5, r2);
      chk_reg(32'(r2 < r1), 32'h1);
      wait_st(ST_CBDONE, 1'b1); settle(3);
      chk_pin(32'(pmode), 32'(PM_SHUTDOWN));
      chk_pin(32'(switches), 32'h0);
      // every cell already under the stop voltage
      @(posedge clk_i) below <= 16'hFFFF;
      wr(A_CTRL, C_GO); wait_st(ST_CBDONE, 1'b1); settle(3);
      chk_pin(32'(switches), 32'h0);
      chk_pin(32'(pmode), 32'(PM_ACTIVE));
      // die and thermistor pausing, then fault abort
      @(posedge clk_i) below <= 16'h0000;
      ctim(2, 32'hC8); wr(A_CTRL, C_FA | C_GO); settle(4);
      @(posedge clk_i) die_temp <= 8'h69;
      settle(6); rd(A_STAT, d); chk_reg(d & 32'h2, 32'h0);
      @(posedge clk_i) die_temp <= 8'h6A;
      wait_st(ST_INPAUSE, 1'b1);
      @(posedge clk_i) die_temp <= 8'h5F;
      settle(6); rd(A_STAT, d); chk_reg(d & 32'h2, 32'h2);
      @(posedge clk_i) die_temp <= 8'h5E;
      wait_st(ST_INPAUSE, 1'b0);
      @(posedge clk_i) therm_over <= 1'b1;
      settle(6); rd(A_STAT, d); chk_reg(d & 32'h2, 32'h0);
      wr(A_CTRL, C_FA | C_TP); wait_st(ST_INPAUSE, 1'b1);
      @(posedge clk_i) therm_over <= 1'b0;
      wait_st(ST_INPAUSE, 1'b0);
      @(posedge clk_i) fault <= 1'b1;
      wait_st(ST_FABORT, 1'b1);
      rd(A_STAT, d); chk_reg(d & 32'h1, 32'h0);
      chk_pin(32'(switches), 32'h0);
      @(posedge clk_i) fault <= 1'b0;
      // module balancing with the stack stop, cells disabled
      for (int i = 0; i < NCH; i++) ctim(i, 32'h0);
      @(posedge clk_i) stack <= 16'h2000;
      aux_running <= 1'b1;
      wr(A_MSTOP, 32'h1000); wr(A_MTIMER, 32'h3C);
      wr(A_CTRL, C_SLP | C_GO); settle(4);
      chk_pin({30'h0, gpio3, gpio3_oe}, 32'h3);
      rd(A_STAT, d); chk_reg(d & 32'h4, 32'h4);
      wr(A_CTRL, C_SLP | C_PS); settle(6);
      chk_pin({30'h0, gpio3, gpio3_oe}, 32'h3);
      @(posedge clk_i) stack <= 16'h0800;
      wait_st(ST_MBDONE, 1'b1); settle(3);
      chk_pin({30'h0, gpio3, gpio3_oe}, 32'h0);
      chk_pin(32'(pmode), 32'(PM_SLEEP));
      // converter stopped: stack under threshold must be ignored
      @(posedge clk_i) aux_running <= 1'b0;
      wr(A_MTIMER, 32'h0A); wr(A_CTRL, C_GO); settle(12);
      rd(A_STAT, d); chk_reg(d & 32'hC, 32'h4);
      wait_st(ST_MBDONE, 1'b1);
      // host abort and fault abort of module balancing
      @(posedge clk_i) aux_running <= 1'b1;
      stack <= 16'h2000;
      wr(A_MTIMER, 32'h3C); wr(A_CTRL, C_GO); settle(4);
      wr(A_MTIMER, 32'h0); wr(A_CTRL, C_GO); settle(4);
      rd(A_STAT, d); chk_reg(d & 32'hC, 32'h0);
      chk_pin({30'h0, gpio3, gpio3_oe}, 32'h0);
      wr(A_MTIMER, 32'h3C); wr(A_CTRL, C_FA | C_GO); settle(4);
      @(posedge clk_i) fault <= 1'b1;
      settle(6); rd(A_STAT, d); chk_reg(d & 32'hC, 32'h0);
      chk_pin({30'h0, gpio3, gpio3_oe}, 32'h0);
      end_sim();
   end
endmodule : cbp_ctrl_test
